//--- logic/gate_select_pkg.sv
// constants for the logic cell gate input selection block
package gate_select_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] GATE_ENABLE_OFFSET = 8'h00;
    localparam logic [7:0] CELL_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] SOURCE_SELECT_OFFSET = 8'h08;
    localparam logic [7:0] GATE_OUT_OFFSET = 8'h0c;
    // reset values
    localparam logic [31:0] GATE_ENABLE_RESET = 32'h0000_0000;
    localparam logic [3:0] GATE_INVERT_RESET = 4'h0;
    localparam logic [11:0] SOURCE_SELECT_RESET = 12'h000;
    // field layout: one byte per gate, two bits per source
    localparam int GATE_FIELD_WIDTH = 8;
    localparam int SOURCE_FIELD_WIDTH = 2;
    localparam int TRUE_BIT_POS = 1;
    localparam int INV_BIT_POS = 0;
    localparam int SELECT_WIDTH = 3;
    // gate output inversion bits in the control register
    localparam int INVERT_FIELD_POS = 16;
    // select fields are four bits apart in the select register
    localparam int SELECT_STRIDE = 4;
    // ahb transfer type and size codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : gate_select_pkg

//--- logic/logic_cell_gate_input_select.sv
// gate input selection stage of a configurable logic cell, ahb-lite slave
//
// Behaviour
// - bits 31:24 hold gate four enables, source four true first, source one inverted last.
// - bits 23:16 hold gate three enables in the same order.
// - bits 15:8 hold gate two enables, source four true at bit 15 down to source one inverted at bit 8.
// - bits 7:0 hold gate one enables, source four true at bit 7 down to source one inverted at bit 0.
// - a set true enable applies the uninverted source signal to its gate.
// - a set inverted enable applies the complement of the source signal to its gate.
// - a clear enable removes that form, and every enable is read/write and resets to zero.
// - each gate output is inverted by its polarity bit when set, else passed unchanged.
// - data source n is the output of selection multiplexer n driven by its three-bit select.
`timescale 1ns/1ns
`default_nettype none
module logic_cell_gate_input_select #(
    parameter int SOURCE_COUNT = 4,
    parameter int GATE_COUNT = 4,
    parameter int CHOICE_COUNT = 8
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CHOICE_COUNT*SOURCE_COUNT-1:0] i_choices,
    output logic [GATE_COUNT-1:0] o_gate_out
);
    // only the documented four-by-four arrangement with 3-bit selects fits
    if (SOURCE_COUNT != 4 || GATE_COUNT != 4 || CHOICE_COUNT != 8) begin : g_chk
        $error("logic_cell_gate_input_select supports 4 sources, 4 gates, 8 choices");
    end

    logic [31:0] gate_enable_r;
    logic [31:0] gate_enable_nxt;
    logic [3:0] gate_invert_r;
    logic [3:0] gate_invert_nxt;
    logic [11:0] source_select_r;
    logic [11:0] source_select_nxt;
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [3:0] gate_out_r;
    logic [3:0] gate_out_nxt;
    logic [3:0] source_val;
    logic [3:0] gate_raw;
    logic access;

    // select one of the eight choices of a multiplexer
    function automatic logic pick(input logic [7:0] choices,
                                  input logic [2:0] sel);
        pick = choices[sel];
    endfunction : pick

    // or of the enabled true and complemented sources for one gate byte
    function automatic logic gate_or(input logic [7:0] en,
                                     input logic [3:0] src);
        logic acc;
        acc = 1'b0;
        for (int s = 0; s < 4; s++) begin
            acc = acc
                | (en[s*gate_select_pkg::SOURCE_FIELD_WIDTH
                      + gate_select_pkg::TRUE_BIT_POS] & src[s])
                | (en[s*gate_select_pkg::SOURCE_FIELD_WIDTH
                      + gate_select_pkg::INV_BIT_POS] & ~src[s]);
        end
        gate_or = acc;
    endfunction : gate_or

    // data source multiplexers
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            // selects are held packed, three bits per multiplexer
            source_val[n] = pick(i_choices[n*8 +: 8],
                source_select_r[n*gate_select_pkg::SELECT_WIDTH +: 3]);
        end
    end

    // gate byte n of the enable register feeds gate n
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            gate_raw[g] = gate_or(
                gate_enable_r[g*gate_select_pkg::GATE_FIELD_WIDTH +: 8],
                source_val);
        end
        gate_out_nxt = gate_raw ^ gate_invert_r;
    end

    assign access = hsel & hready & (htrans == gate_select_pkg::HTRANS_NONSEQ);

    // bus address phase capture, write data phase and read data
    always_comb begin
        gate_enable_nxt = gate_enable_r;
        gate_invert_nxt = gate_invert_r;
        source_select_nxt = source_select_r;
        wr_pend_nxt = 1'b0;
        addr_nxt = addr_r;
        rdata_nxt = rdata_r;
        if (wr_pend_r) begin
            case (addr_r)
                gate_select_pkg::GATE_ENABLE_OFFSET: begin
                    gate_enable_nxt = hwdata;
                end
                gate_select_pkg::CELL_CONTROL_OFFSET: begin
                    gate_invert_nxt =
                        hwdata[gate_select_pkg::INVERT_FIELD_POS +: 4];
                end
                gate_select_pkg::SOURCE_SELECT_OFFSET: begin
                    // drop the unused gap bits so the fields pack to 12 bits
                    source_select_nxt = {hwdata[14:12], hwdata[10:8],
                        hwdata[6:4], hwdata[2:0]};
                end
                default: begin
                    gate_enable_nxt = gate_enable_r; // unmapped: ignored
                end
            endcase
        end
        if (access) begin
            addr_nxt = {haddr[7:2], 2'b00};
            wr_pend_nxt = hwrite;
            case ({haddr[7:2], 2'b00})
                gate_select_pkg::GATE_ENABLE_OFFSET: begin
                    rdata_nxt = gate_enable_nxt;
                end
                gate_select_pkg::CELL_CONTROL_OFFSET: begin
                    rdata_nxt = {12'h000, gate_invert_nxt, 16'h0000};
                end
                gate_select_pkg::SOURCE_SELECT_OFFSET: begin
                    rdata_nxt = {17'h00000, source_select_nxt[11:9], 1'b0,
                        source_select_nxt[8:6], 1'b0, source_select_nxt[5:3],
                        1'b0, source_select_nxt[2:0]};
                end
                gate_select_pkg::GATE_OUT_OFFSET: begin
                    rdata_nxt = {28'h0000000, gate_out_r};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // register all state
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gate_enable_r <= gate_select_pkg::GATE_ENABLE_RESET;
            gate_invert_r <= gate_select_pkg::GATE_INVERT_RESET;
            source_select_r <= gate_select_pkg::SOURCE_SELECT_RESET;
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            gate_out_r <= 4'h0;
        end else begin
            gate_enable_r <= gate_enable_nxt;
            gate_invert_r <= gate_invert_nxt;
            source_select_r <= source_select_nxt;
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
            gate_out_r <= gate_out_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;
    assign o_gate_out = gate_out_r;

    // gate one from enable bits, sources and inversion
    a_gate_one_out: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_gate_out[0] == ($past(gate_or(gate_enable_r[7:0], source_val))
            ^ $past(gate_invert_r[0])))
        else $error("gate one output wrong");
    a_gate_four_out: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_gate_out[3] == ($past(gate_or(gate_enable_r[31:24], source_val))
            ^ $past(gate_invert_r[3])))
        else $error("gate four output wrong");
    a_gate_three_byte: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ($past(gate_enable_r[23:16]) == 8'h00)
            |-> o_gate_out[2] == $past(gate_invert_r[2]))
        else $error("gate three not idle with no enables");
    a_gate_two_true: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ($past(gate_enable_r[15:8]) == 8'h80 && !$past(gate_invert_r[1]))
            |-> o_gate_out[1] == $past(source_val[3]))
        else $error("gate two source four true wrong");
    a_true_pass: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ($past(gate_enable_r[7:0]) == 8'h02 && !$past(gate_invert_r[0]))
            |-> o_gate_out[0] == $past(source_val[0]))
        else $error("true form not passed");
    a_inv_pass: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ($past(gate_enable_r[7:0]) == 8'h01 && !$past(gate_invert_r[0]))
            |-> o_gate_out[0] == !$past(source_val[0]))
        else $error("inverted form not passed");
    a_enable_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (wr_pend_r && addr_r == gate_select_pkg::GATE_ENABLE_OFFSET)
            |=> gate_enable_r == $past(hwdata))
        else $error("enable write lost");
    a_none_invert: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        ($past(gate_enable_r) == 32'h0000_0000)
            |-> o_gate_out == $past(gate_invert_r))
        else $error("polarity with no inputs wrong");
    a_mux_pick: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        source_val[0] == i_choices[source_select_r[2:0]])
        else $error("source one select wrong");
    // source four takes the top choice byte through the top select field
    a_mux_four: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        source_val[3] == i_choices[24 + source_select_r[11:9]])
        else $error("source four select wrong");
    // a select write lands in the packed fields one edge later
    a_select_write: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        (wr_pend_r && addr_r == gate_select_pkg::SOURCE_SELECT_OFFSET)
            |=> source_select_r == {$past(hwdata[14:12]),
                $past(hwdata[10:8]), $past(hwdata[6:4]),
                $past(hwdata[2:0])})
        else $error("select write lost");
    a_or_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (gate_enable_r[15:8] == 8'h00) |-> !gate_raw[1])
        else $error("empty gate not zero");
endmodule : logic_cell_gate_input_select
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the gate input selection block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = gate_select_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] i_choices = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] o_gate_out;
    logic [31:0] rd;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [31:0] EN = 32'(gate_select_pkg::GATE_ENABLE_OFFSET);
    localparam logic [31:0] CTL = 32'(gate_select_pkg::CELL_CONTROL_OFFSET);
    localparam logic [31:0] SEL = 32'(gate_select_pkg::SOURCE_SELECT_OFFSET);
    localparam logic [31:0] STS = 32'(gate_select_pkg::GATE_OUT_OFFSET);
    logic_cell_gate_input_select DUT (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .i_choices(i_choices), .o_gate_out(o_gate_out));
    // 100 ns clock
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    // hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= gate_select_pkg::HTRANS_NONSEQ;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clock); while (hreadyout !== 1'b1);
        r = hrdata;
        if (hresp !== 1'b0) check({31'h0, hresp}, 32'h0);
    endtask : bus
    // reference gate model: per-source mux, or of enabled forms, polarity
    function automatic logic [3:0] model(logic [31:0] en, logic [31:0] ctl,
                                         logic [31:0] sel, logic [31:0] ch);
        logic [3:0] s;
        logic [3:0] g;
        g = 4'h0;
        for (int n = 0; n < 4; n++) s[n] = ch[8*n+sel[4*n+:3]];
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < 4; n++) begin
                g[k] |= (en[8*k+2*n+1] & s[n]) | (en[8*k+2*n] & ~s[n]);
            end
        end
        return g ^ ctl[19:16];
    endfunction : model
    // program the block, then compare gate outputs and status readback
    task automatic apply(input logic [31:0] en, input logic [31:0] ctl,
                         input logic [31:0] sel, input logic [31:0] ch);
        bus(1'b1, EN, en, rd);
        bus(1'b1, CTL, ctl, rd);
        bus(1'b1, SEL, sel, rd);
        i_choices <= ch;
        repeat (3) @(posedge i_clock);
        check({28'h0, o_gate_out}, {28'h0, model(en, ctl, sel, ch)});
        bus(1'b0, STS, 32'h0, rd);
        check(rd, {28'h0, model(en, ctl, sel, ch)});
    endtask : apply
    task automatic test_reset_and_rw();
        bus(1'b0, EN, 32'h0, rd);
        check(rd, gate_select_pkg::GATE_ENABLE_RESET);
        check({28'h0, o_gate_out}, 32'h0);
        bus(1'b1, EN, 32'ha5c3_1e69, rd);
        bus(1'b0, EN, 32'h0, rd);
        check(rd, 32'ha5c3_1e69);
        bus(1'b1, 32'h0000_0010, 32'hffff_ffff, rd);
        bus(1'b0, 32'h0000_0010, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b1, SEL, 32'hffff_ffff, rd);
        bus(1'b0, SEL, 32'h0, rd);
        check(rd, 32'h0000_7777);
        bus(1'b1, CTL, 32'hffff_ffff, rd);
        bus(1'b0, CTL, 32'h0, rd);
        check(rd, 32'h000f_0000);
        bus(1'b0, EN, 32'h0, rd);
        check(rd, 32'ha5c3_1e69);
    endtask : test_reset_and_rw
    // walk each enable bit alone; sources alternate one and zero
    task automatic test_bit_walk();
        for (int i = 0; i < 32; i++) begin
            apply(32'h1 << i, 32'h0, 32'h0, 32'h00ff_00ff);
        end
    endtask : test_bit_walk
    // reset in mid-run clears every register and the gate outputs
    task automatic test_reset_mid();
        bus(1'b1, EN, 32'hffff_ffff, rd);
        bus(1'b1, CTL, 32'h000f_0000, rd);
        bus(1'b1, SEL, 32'h0000_7777, rd);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_clock);
        check({28'h0, o_gate_out}, 32'h0);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        bus(1'b0, EN, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, CTL, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, SEL, 32'h0, rd);
        check(rd, 32'h0);
    endtask : test_reset_mid
    task automatic test_mix();
        apply(32'h0, 32'h000f_0000, 32'h0, 32'hffff_ffff);
        apply(32'h8040_2001, 32'h0, 32'h0000_7531, 32'h8421_a55a);
        apply(32'h5555_5555, 32'h0005_0000, 32'h0000_0246, 32'h0f0f_3c3c);
        apply(32'haaaa_aaaa, 32'h000a_0000, 32'h0000_3210, 32'h1248_8421);
        apply(32'hffff_ffff, 32'h0, 32'h0000_7777, 32'h8080_8080);
        apply(32'h0000_0000, 32'h0, 32'h0, 32'h0);
    endtask : test_mix
    initial begin
        repeat (16) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        test_reset_and_rw();
        test_bit_walk();
        test_mix();
        test_reset_mid();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
